// File: src/gtu_pkg.sv
// Shared constants, field layout and modes of the general timer unit
// Contract
// - Five 16-bit timers, two modules, chainable
// - Coarse timers: timer, gated, counter, encoder modes
// - Timer mode counts the prescaled system clock
// - Counter mode counts input pin events
// - Gated mode counts only while gate permits
// - Coarse resolution is four clocks per step
// - Direction by software or direction pin
// - Encoder mode decodes A/B quadrature
// - Core wrap toggles latch; latch clocks aux
// - Aux timer in capture/reload mode stops
// - Aux capture latches core on pin trigger
// - Aux reload copies into core on trigger
// - Opposite latch edge reloads alternate for PWM
// - Fine resolution is two clocks per step
// - Fine timers use prescaler or external events
// - Fine core wrap toggles latch; clocks fine aux
// - Fine core wrap clocks capcom, reloads core
// - Capture pin edge stores fine aux, optional clear
// - Capture also from core input/direction pins
package gtu_pkg;
  // Timer slots
  localparam int N_TMR = 5;
  localparam int N_COARSE = 3;
  localparam int T_CORE = 0;
  localparam int T_AUXA = 1;
  localparam int T_AUXB = 2;
  localparam int T_FAUX = 3;
  localparam int T_FCORE = 4;
  // Register byte offsets; value and control banks step by one word
  localparam logic [7:0] OFS_VAL0 = 8'h00;
  localparam logic [7:0] OFS_CAPREG = 8'h14;
  localparam logic [7:0] OFS_CTRL0 = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h40;
  // Control word fields
  localparam int CTRL_W = 20;
  localparam int CTL_RUN = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_DOWN = 4;
  localparam int CTL_EXTDIR = 5;
  localparam int CTL_PS_LO = 6;
  localparam int CTL_GATE = 9;
  localparam int CTL_EDGE_LO = 10;
  localparam int CTL_LATCLK = 12;
  localparam int CTL_LATRLD = 13;
  localparam int CTL_CLR = 14;
  localparam int CTL_CSRC_LO = 15;
  localparam int CTL_CEDGE_LO = 17;
  localparam int CTL_FRLD = 19;
  localparam logic [CTRL_W-1:0] CTRL_RST = 20'h00000;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [15:0] CAPREG_RST = 16'h0000;
  // Resolution in system clocks per step and derived prescaler taps
  localparam int COARSE_RES_CYC = 4;
  localparam int FINE_RES_CYC = 2;
  localparam int COARSE_SHIFT = $clog2(COARSE_RES_CYC);
  localparam int FINE_SHIFT = $clog2(FINE_RES_CYC);
  localparam int PRE_W = 10;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    MODE_TIMER = 3'b000,
    MODE_GATED = 3'b001,
    MODE_COUNTER = 3'b010,
    MODE_ENCODER = 3'b011,
    MODE_RELOAD = 3'b100,
    MODE_CAPTURE = 3'b101
  } gtu_mode_e;
endpackage

// File: src/gtu_timer16.sv
// One 16-bit up/down timer cell with load and wrap event
`timescale 1ns/1ps
module gtu_timer16 import gtu_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input wire logic down,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] value_r,
  output logic wrap
);
  logic at_lim;

  // Wrap flags even when a load replaces the count, so reloads can key on it
  assign at_lim = down ? (value_r == 16'h0000) : (value_r == 16'hFFFF);
  assign wrap = step & at_lim;

  // Load beats counting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_r <= TMR_RST;
    end else if (load) begin
      value_r <= load_val;
    end else if (step) begin
      value_r <= down ? value_r - 16'h0001 : value_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ovf_wrap_a: assert property ((step && !down && !load && value_r == 16'hFFFF) |-> wrap ##1 value_r == 16'h0000) else $error("overflow did not wrap");
  unf_wrap_a: assert property ((step && down && !load && value_r == 16'h0000) |-> wrap ##1 value_r == 16'hFFFF) else $error("underflow did not wrap");
endmodule // gtu_timer16

// File: src/gtu_pin_edge.sv
// Edge detection and quadrature decoding for one input/direction pin pair
`timescale 1ns/1ps
module gtu_pin_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_pin,
  input wire logic dir_pin,
  output logic rise,
  output logic fall,
  output logic dir_edge,
  output logic q_step,
  output logic q_up
);
  logic in_q_r;
  logic dir_q_r;
  logic a_chg;
  logic b_chg;

  // Pins are synchronous; one stage of history is enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_q_r <= 1'b0;
      dir_q_r <= 1'b0;
    end else begin
      in_q_r <= in_pin;
      dir_q_r <= dir_pin;
    end
  end

  assign rise = in_pin & ~in_q_r;
  assign fall = ~in_pin & in_q_r;
  assign a_chg = in_pin ^ in_q_r;
  assign b_chg = dir_pin ^ dir_q_r;
  assign dir_edge = b_chg;
  // Both lines moving at once is an illegal jump and is not counted
  assign q_step = a_chg ^ b_chg;
  assign q_up = a_chg ? (in_pin ^ dir_q_r) : ~(dir_pin ^ in_q_r);
endmodule // gtu_pin_edge

// File: src/gtu_top.sv
// General timer unit: coarse and fine timer modules behind AXI4-Lite
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module gtu_top import gtu_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_TMR-1:0] timer_input_pin,
  input wire logic [N_TMR-1:0] timer_direction_pin,
  input wire logic capture_input_pin,
  output logic core_toggle_output,
  output logic fine_toggle_output,
  output logic capcom_clock_pulse
);
  logic [CTRL_W-1:0] ctrl_r [N_TMR];
  gtu_mode_e mode [N_TMR];
  logic [15:0] val [N_TMR];
  logic [15:0] lval [N_TMR];
  logic step [N_TMR];
  logic down [N_TMR];
  logic load [N_TMR];
  logic wrap [N_TMR];
  logic rise [N_TMR];
  logic fall [N_TMR];
  logic dedge [N_TMR];
  logic qstep [N_TMR];
  logic qup [N_TMR];
  logic ev_pin [N_TMR];
  logic ev_lat [N_TMR];
  logic rld [N_TMR];
  logic cap [N_TMR];
  logic [PRE_W-1:0] pre_r;
  logic [15:0] capreg_r;
  logic cap_q_r;
  logic cap_pin_ev;
  logic cap_f;
  logic core_lat_rise;
  logic core_lat_fall;
  logic fine_lat_rise;
  logic fine_lat_fall;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_do;
  logic [32:0] wr_old;
  logic [32:0] rd_now;
  logic [31:0] wr_val;

  // Register view: bit 32 flags an unmapped address
  function automatic logic [32:0] reg_rd(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h00000000};
    for (int k = 0; k < N_TMR; k++) begin
      if (a == OFS_VAL0 + 8'(4 * k)) r = {1'b0, 32'(val[k])};
      if (a == OFS_CTRL0 + 8'(4 * k)) r = {1'b0, 32'(ctrl_r[k])};
    end
    if (a == OFS_CAPREG) r = {1'b0, 32'(capreg_r)};
    if (a == OFS_STAT) r = {1'b0, 30'h00000000, fine_toggle_output, core_toggle_output};
    return r;
  endfunction

  // Byte-lane merge of write data into the old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) m[8*b +: 8] = d[8*b +: 8];
    end
    return m;
  endfunction

  // Write commits once address and data are both held and no answer is pending
  assign wr_do = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign wr_old = reg_rd(aw_addr_r);
  assign wr_val = merge(wr_old[31:0], w_data_r, w_strb_r);
  assign rd_now = reg_rd(s_axi_araddr);

  // Write address channel; ready returns only after the response is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else begin
      if (wr_do) aw_hold_r <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, independent of the address order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else begin
      if (wr_do) w_hold_r <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_old[32] ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_now[31:0];
      s_axi_rresp <= rd_now[32] ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < N_TMR; k++) ctrl_r[k] <= CTRL_RST;
    end else begin
      for (int k = 0; k < N_TMR; k++) begin
        if (wr_do && aw_addr_r == OFS_CTRL0 + 8'(4 * k)) ctrl_r[k] <= wr_val[CTRL_W-1:0];
      end
    end
  end

  // Free-running divider shared by every prescaler tap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pre_r <= '0;
    else pre_r <= pre_r + PRE_W'(1);
  end

  // Latch transitions are known in the cycle of the wrap that causes them
  assign core_lat_rise = wrap[T_CORE] & ~core_toggle_output;
  assign core_lat_fall = wrap[T_CORE] & core_toggle_output;
  assign fine_lat_rise = wrap[T_FCORE] & ~fine_toggle_output;
  assign fine_lat_fall = wrap[T_FCORE] & fine_toggle_output;

  // Per-timer clocking, direction and counting cells
  for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
    localparam int SH = (i < N_COARSE) ? COARSE_SHIFT : FINE_SHIFT;
    logic [PRE_W-1:0] mask;
    logic tick;
    logic run;
    logic lr;
    logic lf;

    assign run = ctrl_r[i][CTL_RUN];
    assign mode[i] = gtu_mode_e'(ctrl_r[i][CTL_MODE_LO +: 3]);
    // Base tap of 4 or 2 clocks, then a further power of two
    assign mask = PRE_W'((32'd1 << (SH + int'(ctrl_r[i][CTL_PS_LO +: 3]))) - 32'd1);
    assign tick = (pre_r & mask) == mask;
    // Coarse aux timers chain on the core latch, fine aux on the fine latch
    assign lr = (i == T_FAUX) ? fine_lat_rise : core_lat_rise;
    assign lf = (i == T_FAUX) ? fine_lat_fall : core_lat_fall;
    assign ev_pin[i] = (ctrl_r[i][CTL_EDGE_LO] & rise[i]) | (ctrl_r[i][CTL_EDGE_LO+1] & fall[i]);
    assign ev_lat[i] = (ctrl_r[i][CTL_EDGE_LO] & lr) | (ctrl_r[i][CTL_EDGE_LO+1] & lf);
    assign rld[i] = (mode[i] == MODE_RELOAD) &&
                    (ctrl_r[i][CTL_LATRLD] ? ev_lat[i] : ev_pin[i]);
    assign cap[i] = (mode[i] == MODE_CAPTURE) && ev_pin[i];

    // Count source by mode; reload and capture modes hold the timer still
    always_comb begin
      case (mode[i])
        MODE_TIMER: step[i] = run & tick;
        MODE_GATED: step[i] = run & tick & (timer_input_pin[i] == ctrl_r[i][CTL_GATE]);
        MODE_COUNTER: step[i] = run & (ctrl_r[i][CTL_LATCLK] ? ev_lat[i] : ev_pin[i]);
        MODE_ENCODER: step[i] = run & qstep[i];
        default: step[i] = 1'b0;
      endcase
    end

    // Quadrature direction in encoder mode, else software direction optionally flipped by the direction pin
    assign down[i] = (mode[i] == MODE_ENCODER) ? ~qup[i] :
                     ctrl_r[i][CTL_DOWN] ^ (ctrl_r[i][CTL_EXTDIR] & timer_direction_pin[i]);

    gtu_pin_edge u_pin (
      .clk(clk),
      .rst(rst),
      .in_pin(timer_input_pin[i]),
      .dir_pin(timer_direction_pin[i]),
      .rise(rise[i]),
      .fall(fall[i]),
      .dir_edge(dedge[i]),
      .q_step(qstep[i]),
      .q_up(qup[i])
    );

    gtu_timer16 u_tmr (
      .clk(clk),
      .rst(rst),
      .step(step[i]),
      .down(down[i]),
      .load(load[i]),
      .load_val(lval[i]),
      .value_r(val[i]),
      .wrap(wrap[i])
    );

    if (i < N_COARSE) begin : g_res_c
      res_coarse_a: assert property (@(posedge clk) disable iff (rst) (mode[i] == MODE_TIMER && step[i]) |-> &pre_r[COARSE_SHIFT-1:0]) else $error("coarse step off the 4-clock grid");
    end else begin : g_res_f
      res_fine_a: assert property (@(posedge clk) disable iff (rst) (mode[i] == MODE_TIMER && step[i]) |-> &pre_r[FINE_SHIFT-1:0]) else $error("fine step off the 2-clock grid");
    end
    gate_hold_a: assert property (@(posedge clk) disable iff (rst) (mode[i] == MODE_GATED && timer_input_pin[i] != ctrl_r[i][CTL_GATE] && !load[i]) |=> $stable(val[i])) else $error("gated timer moved while gate closed");
    stop_hold_a: assert property (@(posedge clk) disable iff (rst) ((mode[i] == MODE_RELOAD || mode[i] == MODE_CAPTURE) && !load[i]) |=> $stable(val[i])) else $error("timer in capture or reload mode moved");
    cnt_event_a: assert property (@(posedge clk) disable iff (rst) (mode[i] == MODE_COUNTER && run && !ctrl_r[i][CTL_LATCLK] && ev_pin[i] && !load[i]) |=> (val[i] == $past(val[i]) + 16'h0001 || val[i] == $past(val[i]) - 16'h0001)) else $error("counter missed a pin event");
    enc_up_a: assert property (@(posedge clk) disable iff (rst) (mode[i] == MODE_ENCODER && run && qstep[i] && qup[i] && !load[i]) |=> val[i] == $past(val[i]) + 16'h0001) else $error("encoder forward step not counted up");
    dir_pin_a: assert property (@(posedge clk) disable iff (rst) (mode[i] == MODE_TIMER && step[i] && !load[i] && ctrl_r[i][CTL_EXTDIR] && timer_direction_pin[i] && !ctrl_r[i][CTL_DOWN]) |=> val[i] == $past(val[i]) - 16'h0001) else $error("direction pin did not reverse count");
  end

  // Capture pin history for the fine capture trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cap_q_r <= 1'b0;
    else cap_q_r <= capture_input_pin;
  end

  assign cap_pin_ev = (ctrl_r[T_FAUX][CTL_CEDGE_LO] & capture_input_pin & ~cap_q_r) |
                      (ctrl_r[T_FAUX][CTL_CEDGE_LO+1] & ~capture_input_pin & cap_q_r);
  // Capture source: own pin, or core input and/or direction pin transitions
  assign cap_f = (ctrl_r[T_FAUX][CTL_CSRC_LO +: 2] == 2'b00) ? cap_pin_ev :
                 ((ctrl_r[T_FAUX][CTL_CSRC_LO] & (rise[T_CORE] | fall[T_CORE])) |
                  (ctrl_r[T_FAUX][CTL_CSRC_LO+1] & dedge[T_CORE]));

  // Loads: software first, hardware events override it; an aux A reload beats a same-cycle aux B reload
  always_comb begin
    for (int k = 0; k < N_TMR; k++) begin
      load[k] = 1'b0;
      lval[k] = 16'h0000;
      if (wr_do && aw_addr_r == OFS_VAL0 + 8'(4 * k)) begin
        load[k] = 1'b1;
        lval[k] = wr_val[15:0];
      end
    end
    // Aux A and B on opposite latch edges alternate, giving hands-free PWM
    if (rld[T_AUXA]) begin
      load[T_CORE] = 1'b1;
      lval[T_CORE] = val[T_AUXA];
    end else if (rld[T_AUXB]) begin
      load[T_CORE] = 1'b1;
      lval[T_CORE] = val[T_AUXB];
    end
    for (int k = T_AUXA; k <= T_AUXB; k++) begin
      if (cap[k]) begin
        load[k] = 1'b1;
        lval[k] = val[T_CORE];
      end
    end
    if (cap_f && ctrl_r[T_FAUX][CTL_CLR]) begin
      load[T_FAUX] = 1'b1;
      lval[T_FAUX] = 16'h0000;
    end
    if (ctrl_r[T_FCORE][CTL_FRLD] && wrap[T_FCORE]) begin
      load[T_FCORE] = 1'b1;
      lval[T_FCORE] = capreg_r;
    end
  end

  // Capture/reload register; a capture beats a same-cycle bus write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) capreg_r <= CAPREG_RST;
    else if (cap_f) capreg_r <= val[T_FAUX];
    else if (wr_do && aw_addr_r == OFS_CAPREG) capreg_r <= wr_val[15:0];
  end

  // Toggle latches and the capcom clock pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_toggle_output <= 1'b0;
      fine_toggle_output <= 1'b0;
      capcom_clock_pulse <= 1'b0;
    end else begin
      if (wrap[T_CORE]) core_toggle_output <= ~core_toggle_output;
      if (wrap[T_FCORE]) fine_toggle_output <= ~fine_toggle_output;
      capcom_clock_pulse <= wrap[T_FCORE];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  core_latch_a: assert property (1'b1 |=> core_toggle_output == ($past(core_toggle_output) ^ $past(wrap[T_CORE]))) else $error("core latch out of step with wraps");
  fine_latch_a: assert property (1'b1 |=> fine_toggle_output == ($past(fine_toggle_output) ^ $past(wrap[T_FCORE]))) else $error("fine latch out of step with wraps");
  capcom_clk_a: assert property (1'b1 |=> capcom_clock_pulse == $past(wrap[T_FCORE])) else $error("capcom pulse not tied to fine wrap");
  fine_reload_a: assert property ((ctrl_r[T_FCORE][CTL_FRLD] && wrap[T_FCORE]) |=> val[T_FCORE] == $past(capreg_r)) else $error("fine core not reloaded from capture register");
  aux_capture_a: assert property (cap[T_AUXA] |=> val[T_AUXA] == $past(val[T_CORE])) else $error("aux A did not capture core");
  core_reload_a: assert property (rld[T_AUXA] |=> val[T_CORE] == $past(val[T_AUXA])) else $error("core not reloaded from aux A");
  pwm_alt_a: assert property ((rld[T_AUXB] && !rld[T_AUXA]) |=> val[T_CORE] == $past(val[T_AUXB])) else $error("core not reloaded from aux B");
  capreg_cap_a: assert property (cap_f |=> capreg_r == $past(val[T_FAUX]) && (!$past(ctrl_r[T_FAUX][CTL_CLR]) || val[T_FAUX] == 16'h0000)) else $error("capture register missed fine aux value");
endmodule // gtu_top

// File: tb/gtu_pin_model.sv
// Far-side pin model: event, gate, direction, encoder and capture pins
`timescale 1ns/1ps
module gtu_pin_model (
  input wire logic clk,
  output logic [4:0] tin,
  output logic [4:0] tdir,
  output logic cap
);
  logic [1:0] ph;
  // Pins start low so the first edges are the ones a scenario asks for
  initial begin
    tin = 5'h00;
    tdir = 5'h00;
    cap = 1'b0;
    ph = 2'h0;
  end
  // Set one gate or count pin to a level
  task automatic lvl(input int i, input logic v);
    @(posedge clk);
    tin[i] <= v;
  endtask
  // Set one direction pin to a level
  task automatic dir(input int i, input logic v);
    @(posedge clk);
    tdir[i] <= v;
  endtask
  // Two edges spaced apart so the edge detector sees each of them
  task automatic pulse(input int i);
    lvl(i, ~tin[i]);
    repeat (3) @(posedge clk);
    lvl(i, ~tin[i]);
    repeat (3) @(posedge clk);
  endtask
  // Rising then falling edge on the capture pin
  task automatic cap_pulse();
    @(posedge clk);
    cap <= 1'b1;
    repeat (3) @(posedge clk);
    cap <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // One quadrature step; a real sensor changes only A or B at a time
  task automatic quad(input int i, input logic up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    @(posedge clk);
    tin[i] <= ph[1] ^ ph[0];
    tdir[i] <= ph[1];
    repeat (3) @(posedge clk);
  endtask
endmodule // gtu_pin_model

// File: tb/gtu_top_tb.sv
// Self-checking bench for the general timer unit
`timescale 1ns/1ps
module gtu_top_tb;
  import gtu_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cap, core_out, fine_out, ccp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rd_r;
  logic [4:0] tin, tdir;
  logic [3:0] wstrb;
  int errors, n_compared, pulses, p0;
  gtu_top u_gtu_top (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_input_pin(tin), .timer_direction_pin(tdir), .capture_input_pin(cap),
    .core_toggle_output(core_out), .fine_toggle_output(fine_out), .capcom_clock_pulse(ccp));
  gtu_pin_model u_gtu_pin_model (.clk(clk), .tin(tin), .tdir(tdir), .cap(cap));
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count pulses towards the second capture/compare unit
  always @(posedge clk) begin
    if (ccp === 1'b1) pulses <= pulses + 1;
  end
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Window check, for counts whose phase against the prescaler is free
  task automatic rng(input string nm, input logic [15:0] lo, hi, got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  // Handshakes are judged at the falling edge, where the ready the next rise samples is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid & bready;
      n++;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end while (b_hs !== 1'b1 && n < 200);
    if (b_hs !== 1'b1) chk("write answer", 32'h1, 32'h0);
    if (b_hs !== 1'b1) wrap_up();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_hs = arvalid & arready;
      r_hs = rvalid & rready;
      rd_v = rdata;
      rd_r = rresp;
      n++;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end while (r_hs !== 1'b1 && n < 200);
    if (r_hs !== 1'b1) chk("read answer", 32'h1, 32'h0);
    if (r_hs !== 1'b1) wrap_up();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a);
    chk(nm, exp, rd_v);
  endtask
  task automatic t_regs();
    rdc(OFS_CTRL0, 32'h0, "core control reset");
    wr(OFS_VAL0, 32'hFFFF1234);
    rdc(OFS_VAL0, 32'h1234, "core value width");
    // Low byte lane only; the upper byte of the value must survive
    wstrb <= 4'h1;
    wr(OFS_VAL0, 32'h000000AB);
    wstrb <= 4'hF;
    rdc(OFS_VAL0, 32'h12AB, "core byte lane write");
    rd(8'h18);
    chk("unmapped answer", RESP_SLVERR, rd_r);
  endtask
  // Both modules run the same window; the fine one steps twice as often
  task automatic t_rate();
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    wr(OFS_CTRL0, 32'h1);
    wr(8'h30, 32'h1);
    repeat (400) @(posedge clk);
    wr(OFS_CTRL0, 32'h0);
    wr(8'h30, 32'h0);
    rd(8'h00);
    rng("coarse count", 16'h0063, 16'h0068, rd_v[15:0]);
    rd(8'h10);
    rng("fine count", 16'h00C7, 16'h00CF, rd_v[15:0]);
  endtask
  task automatic t_wrap();
    wr(8'h00, 32'h0);
    wr(OFS_CTRL0, 32'h11);
    repeat (40) @(posedge clk);
    wr(OFS_CTRL0, 32'h0);
    rd(8'h00);
    rng("down wrap", 16'hFFF0, 16'hFFFE, rd_v[15:0]);
    chk("core latch pin", 32'h1, {31'h0, core_out});
    rd(OFS_STAT);
    chk("core latch status", 32'h1, {31'h0, rd_v[0]});
  endtask
  task automatic t_fine_wrap();
    p0 = pulses;
    wr(8'h10, 32'hFFF8);
    wr(8'h30, 32'h1);
    repeat (60) @(posedge clk);
    wr(8'h30, 32'h0);
    chk("capcom pulses", 32'h1, pulses - p0);
    chk("fine latch pin", 32'h1, {31'h0, fine_out});
  endtask
  task automatic t_gated();
    wr(8'h00, 32'h0);
    wr(OFS_CTRL0, 32'h203);
    u_gtu_pin_model.lvl(0, 1'b1);
    repeat (400) @(posedge clk);
    u_gtu_pin_model.lvl(0, 1'b0);
    repeat (100) @(posedge clk);
    wr(OFS_CTRL0, 32'h0);
    rd(8'h00);
    rng("gated count", 16'h0062, 16'h0066, rd_v[15:0]);
  endtask
  task automatic t_counter();
    wr(8'h04, 32'h0);
    wr(8'h24, 32'h405);
    repeat (5) u_gtu_pin_model.pulse(1);
    rdc(8'h04, 32'h5, "event count");
    u_gtu_pin_model.dir(1, 1'b1);
    wr(8'h24, 32'h425);
    repeat (2) u_gtu_pin_model.pulse(1);
    rdc(8'h04, 32'h3, "pin direction");
    wr(8'h24, 32'h0);
  endtask
  task automatic t_enc();
    wr(8'h08, 32'h0);
    wr(8'h28, 32'h7);
    repeat (8) u_gtu_pin_model.quad(2, 1'b1);
    repeat (3) u_gtu_pin_model.quad(2, 1'b0);
    rdc(8'h08, 32'h5, "encoder position");
    wr(8'h28, 32'h0);
  endtask
  // Capture into aux A, then reload the core from aux B, which must not move
  task automatic t_caprld();
    wr(8'h00, 32'h1234);
    wr(8'h24, 32'h40A);
    u_gtu_pin_model.pulse(1);
    rdc(8'h04, 32'h1234, "aux capture");
    wr(8'h24, 32'h0);
    wr(8'h08, 32'h0ABC);
    wr(8'h28, 32'h408);
    u_gtu_pin_model.pulse(2);
    rdc(8'h00, 32'h0ABC, "core reload");
    rdc(8'h08, 32'h0ABC, "reload aux held");
    wr(8'h28, 32'h0);
  endtask
  task automatic t_capture_reload_register();
    wr(8'h0C, 32'h42);
    wr(8'h2C, 32'h24000);
    u_gtu_pin_model.cap_pulse();
    rdc(OFS_CAPREG, 32'h42, "capture register");
    rdc(8'h0C, 32'h0, "fine aux cleared");
    wr(8'h0C, 32'h77);
    wr(8'h2C, 32'h8000);
    u_gtu_pin_model.pulse(0);
    rdc(OFS_CAPREG, 32'h77, "core pin capture");
    wr(8'h2C, 32'h0);
  endtask
  // Reset for 16 cycles, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    errors = 0;
    n_compared = 0;
    pulses = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rate();
    t_wrap();
    t_fine_wrap();
    t_gated();
    t_counter();
    t_enc();
    t_caprld();
    t_capture_reload_register();
    wrap_up();
  end
endmodule // gtu_top_tb
